// ==== common/dltc_pkg.sv ====
// Purpose: constants and types of the debug low-power and trace configuration unit
// Assumes: 32-bit word register port on the private peripheral bus
// Notes: all offsets, field positions and reset values live here
package dltc_pkg;

  // register addresses
  localparam logic [31:0] DLTC_CFG_ADDR = 32'hE0042004;
  localparam logic [31:0] DLTC_FRZ_ADDR = 32'hE0042008;
  localparam logic [31:0] DLTC_STAT_ADDR = 32'hE0042010;

  // reset values and writable masks
  localparam logic [31:0] DLTC_CFG_RESET = 32'h00000000;
  localparam logic [31:0] DLTC_FRZ_RESET = 32'h00000000;
  localparam logic [31:0] DLTC_CFG_MASK = 32'h000000E7;
  localparam logic [31:0] DLTC_FRZ_MASK = 32'h0003FFFF;

  // debug_configuration fields
  localparam int DLTC_SLEEP_KEEP_BIT = 0;
  localparam int DLTC_STOP_KEEP_BIT = 1;
  localparam int DLTC_STANDBY_KEEP_BIT = 2;
  localparam int DLTC_TRACE_EN_BIT = 5;
  localparam int DLTC_TRACE_MODE_LSB = 6;
  localparam int DLTC_TRACE_MODE_MSB = 7;

  // freeze_select fields
  localparam int DLTC_FRZ_CNT_N = 16;
  localparam int DLTC_FRZ_CAN_BIT = 16;
  localparam int DLTC_FRZ_SMB_BIT = 17;
  localparam int DLTC_FRZ_W = 18;

  // status fields
  localparam int DLTC_ST_PWR_LSB = 0;
  localparam int DLTC_ST_PWR_MSB = 1;
  localparam int DLTC_ST_HALT_BIT = 2;
  localparam int DLTC_ST_SYSRST_BIT = 3;
  localparam int DLTC_ST_STBYRST_BIT = 4;

  // transfer size code of a full word
  localparam logic [1:0] DLTC_SIZE_WORD = 2'h2;

  typedef enum logic [1:0] {
    DLTC_TR_ASYNC = 2'h0,
    DLTC_TR_SYNC1 = 2'h1,
    DLTC_TR_SYNC2 = 2'h2,
    DLTC_TR_SYNC4 = 2'h3
  } dltc_trace_e;

  typedef enum logic [1:0] {
    DLTC_PWR_RUN = 2'h0,
    DLTC_PWR_SLEEP = 2'h1,
    DLTC_PWR_STOP = 2'h3,
    DLTC_PWR_STANDBY = 2'h2
  } dltc_pwr_e;

endpackage

// ==== common/dltc_cfg_if.sv ====
// Purpose: carries configuration from the register file to the helper modules
// Assumes: single clock domain
// Notes: driven only by the top module
`timescale 1ns/1ps
interface dltc_cfg_if;
  import dltc_pkg::*;
  logic trace_en;
  logic [1:0] trace_mode;
  logic [DLTC_FRZ_W-1:0] frz_sel;
  logic halted;
  modport ctrl (output trace_en, output trace_mode, output frz_sel, output halted);
  modport trace (input trace_en, input trace_mode);
  modport freeze (input frz_sel, input halted);
endinterface

// ==== design/dltc_freeze_gate.sv ====
// Purpose: per-peripheral clock run enables while the core is halted
// Assumes: halted is a level synchronous to clk
// Notes: one bit per frozen function, width set by parameter
`timescale 1ns/1ps
module dltc_freeze_gate #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  dltc_cfg_if.freeze cfg,
  output logic [W-1:0] run_en
);
  logic [W-1:0] run_reg;
  logic [W-1:0] run_next;

  always_comb begin
    run_next = ~(cfg.frz_sel[W-1:0] & {W{cfg.halted}});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= '1;
    end else begin
      run_reg <= run_next;
    end
  end

  assign run_en = run_reg;
endmodule // dltc_freeze_gate

// ==== design/dltc_trace_pins.sv ====
// Purpose: trace pin assignment from enable and layout
// Assumes: layout field may change at any time
// Notes: outputs are registered levels
`timescale 1ns/1ps
module dltc_trace_pins
  import dltc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dltc_cfg_if.trace cfg,
  output logic async_pin_en,
  output logic clk_pin_en,
  output logic [3:0] lane_en
);
  logic async_reg;
  logic async_next;
  logic clk_reg;
  logic clk_next;
  logic [3:0] lane_reg;
  logic [3:0] lane_next;

  always_comb begin
    async_next = 1'b0;
    clk_next = 1'b0;
    lane_next = 4'h0;
    if (cfg.trace_en) begin
      unique case (dltc_trace_e'(cfg.trace_mode))
        DLTC_TR_ASYNC: async_next = 1'b1;
        DLTC_TR_SYNC1: begin
          clk_next = 1'b1;
          lane_next = 4'h1;
        end
        DLTC_TR_SYNC2: begin
          clk_next = 1'b1;
          lane_next = 4'h3;
        end
        DLTC_TR_SYNC4: begin
          clk_next = 1'b1;
          lane_next = 4'hF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      async_reg <= 1'b0;
      clk_reg <= 1'b0;
      lane_reg <= 4'h0;
    end else begin
      async_reg <= async_next;
      clk_reg <= clk_next;
      lane_reg <= lane_next;
    end
  end

  assign async_pin_en = async_reg;
  assign clk_pin_en = clk_reg;
  assign lane_en = lane_reg;
endmodule // dltc_trace_pins

// ==== design/dltc_top.sv ====
// Purpose: debug configuration unit: low-power clock keeping, trace pins, halt freezing
// Assumes: NRST is the power-on reset; SYS_NRST is the system reset
// Notes: registers answer on the private peripheral bus port, one word each
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dltc_top
  import dltc_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic SYS_NRST,
  input wire logic PPB_SEL,
  input wire logic PPB_WRITE,
  input wire logic [31:0] PPB_ADDR,
  input wire logic [1:0] PPB_SIZE,
  input wire logic [31:0] PPB_WDATA,
  output logic [31:0] PPB_RDATA,
  output logic PPB_ERR,
  input wire logic CORE_HALTED,
  input wire logic LP_SLEEP,
  input wire logic LP_STOP,
  input wire logic LP_STANDBY,
  output logic SLEEP_CLOCK_KEEP,
  output logic STOP_CLOCK_KEEP,
  output logic STANDBY_POWER_KEEP,
  output logic CORE_CLK_EN,
  output logic BUS_CLK_EN,
  output logic CORE_CLK_FROM_RCOSC,
  output logic RCOSC_KEEP_ON,
  output logic DIGITAL_POWER_ON,
  output logic STANDBY_SYS_RESET,
  output logic CLK_CFG_DEFAULT,
  output logic TICK_CLK_EN,
  output logic TRACE_PIN_EN,
  output logic [1:0] TRACE_LAYOUT,
  output logic TRACE_ASYNC_PIN_EN,
  output logic TRACE_CLK_PIN_EN,
  output logic [3:0] TRACE_LANE_EN,
  output logic [DLTC_FRZ_CNT_N-1:0] CNT_CLK_EN,
  output logic CAN_RX_HOLD,
  output logic SMBUS_TIMEOUT_HOLD
);

  //////////////////////////////////////////////////////////////////////////////
  // power-on reset release
  logic por_meta_reg;
  logic por_sync_reg;
  logic rst_n;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      por_meta_reg <= 1'b0;
      por_sync_reg <= 1'b0;
    end else begin
      por_meta_reg <= 1'b1;
      por_sync_reg <= por_meta_reg;
    end
  end

  assign rst_n = por_sync_reg;

  //////////////////////////////////////////////////////////////////////////////
  // register port
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [DLTC_FRZ_W-1:0] frz_reg;
  logic [DLTC_FRZ_W-1:0] frz_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic [31:0] status_word;
  logic hit_cfg;
  logic hit_frz;
  logic hit_stat;
  logic word_ok;
  dltc_pwr_e pwr_reg;
  logic stby_rst_reg;

  assign hit_cfg = (PPB_ADDR == DLTC_CFG_ADDR);
  assign hit_frz = (PPB_ADDR == DLTC_FRZ_ADDR);
  assign hit_stat = (PPB_ADDR == DLTC_STAT_ADDR);
  assign word_ok = (PPB_SIZE == DLTC_SIZE_WORD);

  always_comb begin
    status_word = 32'h00000000;
    status_word[DLTC_ST_PWR_MSB:DLTC_ST_PWR_LSB] = pwr_reg;
    status_word[DLTC_ST_HALT_BIT] = CORE_HALTED;
    status_word[DLTC_ST_SYSRST_BIT] = ~SYS_NRST;
    status_word[DLTC_ST_STBYRST_BIT] = stby_rst_reg;
  end

  // system reset does not gate the write path, so debugger and software both reach it
  always_comb begin
    cfg_next = cfg_reg;
    frz_next = frz_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    if (PPB_SEL) begin
      if (!word_ok || !(hit_cfg || hit_frz || hit_stat)) begin
        err_next = 1'b1;
        rdata_next = 32'h00000000;
      end else if (PPB_WRITE) begin
        if (hit_cfg) begin
          cfg_next = PPB_WDATA & DLTC_CFG_MASK;
        end
        if (hit_frz) begin
          frz_next = PPB_WDATA[DLTC_FRZ_W-1:0];
        end
      end else begin
        if (hit_cfg) begin
          rdata_next = cfg_reg & DLTC_CFG_MASK;
        end else if (hit_frz) begin
          rdata_next = {{(32-DLTC_FRZ_W){1'b0}}, frz_reg};
        end else begin
          rdata_next = status_word;
        end
      end
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= DLTC_CFG_RESET;
      frz_reg <= DLTC_FRZ_RESET[DLTC_FRZ_W-1:0];
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      frz_reg <= frz_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign PPB_RDATA = rdata_reg;
  assign PPB_ERR = err_reg;

  //////////////////////////////////////////////////////////////////////////////
  // configuration levels
  logic sleep_keep;
  logic stop_keep;
  logic standby_keep;

  assign sleep_keep = cfg_reg[DLTC_SLEEP_KEEP_BIT];
  assign stop_keep = cfg_reg[DLTC_STOP_KEEP_BIT];
  assign standby_keep = cfg_reg[DLTC_STANDBY_KEEP_BIT];

  assign SLEEP_CLOCK_KEEP = sleep_keep;
  assign STOP_CLOCK_KEEP = stop_keep;
  assign STANDBY_POWER_KEEP = standby_keep;
  assign TRACE_PIN_EN = cfg_reg[DLTC_TRACE_EN_BIT];
  assign TRACE_LAYOUT = cfg_reg[DLTC_TRACE_MODE_MSB:DLTC_TRACE_MODE_LSB];

  //////////////////////////////////////////////////////////////////////////////
  // low-power mode tracking and clock steering
  dltc_pwr_e pwr_next;
  logic core_en_reg;
  logic core_en_next;
  logic bus_en_reg;
  logic bus_en_next;
  logic rc_src_reg;
  logic rc_src_next;
  logic rc_on_reg;
  logic rc_on_next;
  logic pwr_on_reg;
  logic pwr_on_next;
  logic stby_rst_next;
  logic cfg_dflt_reg;
  logic cfg_dflt_next;

  always_comb begin
    if (LP_STANDBY) begin
      pwr_next = DLTC_PWR_STANDBY;
    end else if (LP_STOP) begin
      pwr_next = DLTC_PWR_STOP;
    end else if (LP_SLEEP) begin
      pwr_next = DLTC_PWR_SLEEP;
    end else begin
      pwr_next = DLTC_PWR_RUN;
    end
  end

  always_comb begin
    core_en_next = 1'b1;
    bus_en_next = 1'b1;
    rc_src_next = 1'b0;
    rc_on_next = 1'b0;
    pwr_on_next = 1'b1;
    stby_rst_next = 1'b0;
    cfg_dflt_next = 1'b0;
    unique case (pwr_next)
      DLTC_PWR_RUN: begin
        // stop and standby exits come back on the power-on clock setup
        cfg_dflt_next = (pwr_reg == DLTC_PWR_STOP) ||
                        (pwr_reg == DLTC_PWR_STANDBY);
      end
      DLTC_PWR_SLEEP: begin
        bus_en_next = sleep_keep;
      end
      DLTC_PWR_STOP: begin
        core_en_next = stop_keep;
        bus_en_next = stop_keep;
        rc_src_next = stop_keep;
        rc_on_next = stop_keep;
      end
      DLTC_PWR_STANDBY: begin
        core_en_next = standby_keep;
        bus_en_next = standby_keep;
        rc_src_next = standby_keep;
        rc_on_next = standby_keep;
        pwr_on_next = standby_keep;
        stby_rst_next = standby_keep;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= DLTC_PWR_RUN;
      core_en_reg <= 1'b1;
      bus_en_reg <= 1'b1;
      rc_src_reg <= 1'b0;
      rc_on_reg <= 1'b0;
      pwr_on_reg <= 1'b1;
      stby_rst_reg <= 1'b0;
      cfg_dflt_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      core_en_reg <= core_en_next;
      bus_en_reg <= bus_en_next;
      rc_src_reg <= rc_src_next;
      rc_on_reg <= rc_on_next;
      pwr_on_reg <= pwr_on_next;
      stby_rst_reg <= stby_rst_next;
      cfg_dflt_reg <= cfg_dflt_next;
    end
  end

  assign CORE_CLK_EN = core_en_reg;
  assign BUS_CLK_EN = bus_en_reg;
  assign CORE_CLK_FROM_RCOSC = rc_src_reg;
  assign RCOSC_KEEP_ON = rc_on_reg;
  assign DIGITAL_POWER_ON = pwr_on_reg;
  assign STANDBY_SYS_RESET = stby_rst_reg;
  assign CLK_CFG_DEFAULT = cfg_dflt_reg;
  // tick timer follows the core clock only; halt freezing never reaches it
  assign TICK_CLK_EN = core_en_reg;

  //////////////////////////////////////////////////////////////////////////////
  // trace pins and halt freezing
  dltc_cfg_if cfg_bus ();
  logic [DLTC_FRZ_W-1:0] run_en;

  assign cfg_bus.trace_en = cfg_reg[DLTC_TRACE_EN_BIT];
  assign cfg_bus.trace_mode = cfg_reg[DLTC_TRACE_MODE_MSB:DLTC_TRACE_MODE_LSB];
  assign cfg_bus.frz_sel = frz_reg;
  assign cfg_bus.halted = CORE_HALTED;

  dltc_trace_pins u_trace (
    .clk(MCLK),
    .rst_n(rst_n),
    .cfg(cfg_bus.trace),
    .async_pin_en(TRACE_ASYNC_PIN_EN),
    .clk_pin_en(TRACE_CLK_PIN_EN),
    .lane_en(TRACE_LANE_EN)
  );

  dltc_freeze_gate #(
    .W(DLTC_FRZ_W)
  ) u_freeze (
    .clk(MCLK),
    .rst_n(rst_n),
    .cfg(cfg_bus.freeze),
    .run_en(run_en)
  );

  assign CNT_CLK_EN = run_en[DLTC_FRZ_CNT_N-1:0];
  assign CAN_RX_HOLD = ~run_en[DLTC_FRZ_CAN_BIT];
  assign SMBUS_TIMEOUT_HOLD = ~run_en[DLTC_FRZ_SMB_BIT];

endmodule // dltc_top

// ==== verification/dltc_top_assertions.sv ====
// Purpose: port checks of the debug configuration unit
// Assumes: checks start three clocks after power-on reset release
// Notes: attached by bind below
`timescale 1ns/1ps
module dltc_top_assertions
  import dltc_pkg::*;
(
  input logic MCLK,
  input logic NRST,
  input logic PPB_SEL,
  input logic PPB_WRITE,
  input logic [31:0] PPB_ADDR,
  input logic [1:0] PPB_SIZE,
  input logic [31:0] PPB_WDATA,
  input logic [31:0] PPB_RDATA,
  input logic PPB_ERR,
  input logic CORE_HALTED,
  input logic LP_SLEEP,
  input logic LP_STOP,
  input logic LP_STANDBY,
  input logic SLEEP_CLOCK_KEEP,
  input logic STOP_CLOCK_KEEP,
  input logic STANDBY_POWER_KEEP,
  input logic CORE_CLK_EN,
  input logic BUS_CLK_EN,
  input logic CLK_CFG_DEFAULT,
  input logic TRACE_PIN_EN,
  input logic [1:0] TRACE_LAYOUT,
  input logic TRACE_ASYNC_PIN_EN,
  input logic TRACE_CLK_PIN_EN,
  input logic [3:0] TRACE_LANE_EN,
  input logic [DLTC_FRZ_CNT_N-1:0] CNT_CLK_EN,
  input logic CAN_RX_HOLD,
  input logic SMBUS_TIMEOUT_HOLD
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  wire [5:0] cfg6 = {TRACE_LAYOUT, TRACE_PIN_EN, STANDBY_POWER_KEEP, STOP_CLOCK_KEEP,
    SLEEP_CLOCK_KEEP};
  wire cfg_acc = PPB_SEL && PPB_ADDR == DLTC_CFG_ADDR && PPB_SIZE == DLTC_SIZE_WORD;

  ////////////////////////////////////////////////////////////////////////////////
  // edges since reset release
  always_comb begin
    cnt_next = (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
  end
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!NRST || cnt_reg != 2'h3);

  ////////////////////////////////////////////////////////////////////////////////
  property p_read;
    cfg_acc && !PPB_WRITE |=> PPB_RDATA == {24'h0, $past(cfg6[5:3]), 2'h0, $past(cfg6[2:0])};
  endproperty
  a_read: assert property (p_read) else $error("config read wrong");
  property p_write;
    cfg_acc && PPB_WRITE |=> cfg6 == {$past(PPB_WDATA[7:5]), $past(PPB_WDATA[2:0])};
  endproperty
  a_write: assert property (p_write) else $error("config write lost");
  property p_hold;
    !(PPB_SEL && PPB_WRITE) |=> $stable(cfg6);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed");
  property p_size;
    PPB_SEL && PPB_SIZE != DLTC_SIZE_WORD |=> PPB_ERR && PPB_RDATA == 32'h0;
  endproperty
  a_size: assert property (p_size) else $error("narrow access not refused");
  property p_off;
    !TRACE_PIN_EN |=> !TRACE_ASYNC_PIN_EN && !TRACE_CLK_PIN_EN && TRACE_LANE_EN == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("trace pins assigned");
  property p_layout;
    TRACE_PIN_EN |=> TRACE_ASYNC_PIN_EN == ($past(TRACE_LAYOUT) == 2'h0)
      && TRACE_CLK_PIN_EN == ($past(TRACE_LAYOUT) != 2'h0);
  endproperty
  a_layout: assert property (p_layout) else $error("trace layout wrong");
  property p_sleep;
    LP_SLEEP && !LP_STOP && !LP_STANDBY |=> CORE_CLK_EN && BUS_CLK_EN == $past(SLEEP_CLOCK_KEEP);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_stop;
    LP_STOP && !LP_STANDBY && !STOP_CLOCK_KEEP |=> !CORE_CLK_EN && !BUS_CLK_EN;
  endproperty
  a_stop: assert property (p_stop) else $error("stop clocks running");
  property p_dflt;
    LP_STOP ##1 (!LP_SLEEP && !LP_STOP && !LP_STANDBY) |=> CLK_CFG_DEFAULT ##1 !CLK_CFG_DEFAULT;
  endproperty
  a_dflt: assert property (p_dflt) else $error("no default pulse");
  property p_frz;
    !CORE_HALTED |=> (&CNT_CLK_EN) && !CAN_RX_HOLD && !SMBUS_TIMEOUT_HOLD;
  endproperty
  a_frz: assert property (p_frz) else $error("frozen while running");
endmodule // dltc_top_assertions

bind dltc_top dltc_top_assertions dltc_top_assertions_inst (.*);

// ==== verification/dltc_host_model.sv ====
// Purpose: debugger host model on the private peripheral bus port
// Assumes: requests change at the falling clock edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
module dltc_host_model (
  input logic MCLK,
  output logic PPB_SEL,
  output logic PPB_WRITE,
  output logic [31:0] PPB_ADDR,
  output logic [1:0] PPB_SIZE,
  output logic [31:0] PPB_WDATA,
  input logic [31:0] PPB_RDATA,
  input logic PPB_ERR
);
  initial begin
    PPB_SEL = 1'b0;
    PPB_WRITE = 1'b0;
    PPB_ADDR = 32'h0;
    PPB_SIZE = 2'h0;
    PPB_WDATA = 32'h0;
  end

  // one access over one rising edge, answer taken in the next cycle
  task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] sz,
    input logic [31:0] d, output logic [31:0] rd, output logic e);
    @(negedge MCLK);
    PPB_SEL = 1'b1;
    PPB_WRITE = w;
    PPB_ADDR = a;
    PPB_SIZE = sz;
    PPB_WDATA = d;
    @(negedge MCLK);
    rd = PPB_RDATA;
    e = PPB_ERR;
    PPB_SEL = 1'b0;
    PPB_ADDR = ~a;
    PPB_WDATA = ~d;
  endtask
endmodule // dltc_host_model

// ==== verification/testbench.sv ====
// Purpose: self-checking bench of the debug configuration unit
// Assumes: host model drives the register port, bench the rest
// Notes: inputs change at the falling clock edge
`timescale 1ns/1ps
module testbench
  import dltc_pkg::*;
;
  logic MCLK, NRST, SYS_NRST, CORE_HALTED, LP_SLEEP, LP_STOP, LP_STANDBY;
  logic PPB_SEL, PPB_WRITE, PPB_ERR, SLEEP_CLOCK_KEEP, STOP_CLOCK_KEEP, STANDBY_POWER_KEEP;
  logic [1:0] PPB_SIZE, TRACE_LAYOUT;
  logic [31:0] PPB_ADDR, PPB_WDATA, PPB_RDATA, r;
  logic CORE_CLK_EN, BUS_CLK_EN, CORE_CLK_FROM_RCOSC, RCOSC_KEEP_ON, DIGITAL_POWER_ON;
  logic STANDBY_SYS_RESET, CLK_CFG_DEFAULT, TICK_CLK_EN, TRACE_PIN_EN, TRACE_ASYNC_PIN_EN;
  logic TRACE_CLK_PIN_EN, CAN_RX_HOLD, SMBUS_TIMEOUT_HOLD, e;
  logic [3:0] TRACE_LANE_EN;
  logic [DLTC_FRZ_CNT_N-1:0] CNT_CLK_EN;
  logic [3:0] lane_tab [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
  int n_mismatch = 0;
  int checked = 0;

  dltc_top dltc_top_inst (.*);
  dltc_host_model dltc_host_model_inst (.*);

  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    dltc_host_model_inst.acc(1'b1, a, DLTC_SIZE_WORD, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a);
    dltc_host_model_inst.acc(1'b0, a, DLTC_SIZE_WORD, 32'h0, r, e);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    NRST = 1'b0;
    SYS_NRST = 1'b1;
    CORE_HALTED = 1'b0;
    {LP_STANDBY, LP_STOP, LP_SLEEP} = 3'h0;
    repeat (5) @(negedge MCLK);
    NRST = 1'b1;
    repeat (3) @(negedge MCLK);
    rd(DLTC_CFG_ADDR);
    chk("cfg reset", r, 32'h0);
    SYS_NRST = 1'b0;
    rd(DLTC_STAT_ADDR);
    chk("status in system reset", r, 32'h00000008);
    wr(DLTC_CFG_ADDR, 32'hFFFFFFFF);
    rd(DLTC_CFG_ADDR);
    chk("cfg in system reset", r, 32'h000000E7);
    SYS_NRST = 1'b1;
    dltc_host_model_inst.acc(1'b1, DLTC_CFG_ADDR, 2'h1, 32'h0, r, e);
    chk("narrow error", 32'(e), 32'h1);
    rd(32'hE0042000);
    chk("unmapped error", 32'(e), 32'h1);
    rd(DLTC_CFG_ADDR);
    chk("cfg kept", r, 32'h000000E7);
    for (int m = 0; m < 4; m++) begin
      wr(DLTC_CFG_ADDR, 32'(m << 6) | 32'h20);
      @(negedge MCLK);
      chk("async pin", 32'(TRACE_ASYNC_PIN_EN), 32'(m == 0));
      chk("clock pin", 32'(TRACE_CLK_PIN_EN), 32'(m != 0));
      chk("lanes", 32'(TRACE_LANE_EN), 32'(lane_tab[m]));
    end
    wr(DLTC_CFG_ADDR, 32'hC0);
    @(negedge MCLK);
    chk("pins off", 32'({TRACE_ASYNC_PIN_EN, TRACE_CLK_PIN_EN, TRACE_LANE_EN}), 32'h0);
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 2; k++) begin
        wr(DLTC_CFG_ADDR, 32'(k << i));
        chk("keep", 32'({STANDBY_POWER_KEEP, STOP_CLOCK_KEEP, SLEEP_CLOCK_KEEP}),
          32'(k << i));
        {LP_STANDBY, LP_STOP, LP_SLEEP} = 3'(1 << i);
        @(negedge MCLK);
        chk("core clock", 32'(CORE_CLK_EN), 32'(i == 0 || k == 1));
        chk("tick clock", 32'(TICK_CLK_EN), 32'(i == 0 || k == 1));
        chk("bus clock", 32'(BUS_CLK_EN), 32'(k));
        chk("power", 32'(DIGITAL_POWER_ON), 32'(i != 2 || k == 1));
        chk("rc feed", 32'(CORE_CLK_FROM_RCOSC), 32'(i != 0 && k == 1));
        chk("rc keep on", 32'(RCOSC_KEEP_ON), 32'(i != 0 && k == 1));
        chk("standby reset", 32'(STANDBY_SYS_RESET), 32'(i == 2 && k == 1));
        {LP_STANDBY, LP_STOP, LP_SLEEP} = 3'h0;
        @(negedge MCLK);
        chk("clock defaults", 32'(CLK_CFG_DEFAULT), 32'(i != 0));
      end
    end
    wr(DLTC_FRZ_ADDR, 32'h00030005);
    rd(DLTC_FRZ_ADDR);
    chk("freeze select", r, 32'h00030005);
    CORE_HALTED = 1'b1;
    @(negedge MCLK);
    chk("counter clocks", 32'(CNT_CLK_EN), 32'h0000FFFA);
    chk("can hold", 32'(CAN_RX_HOLD), 32'h1);
    chk("smbus hold", 32'(SMBUS_TIMEOUT_HOLD), 32'h1);
    chk("tick halted", 32'(TICK_CLK_EN), 32'h1);
    CORE_HALTED = 1'b0;
    @(negedge MCLK);
    chk("counters run", 32'(CNT_CLK_EN), 32'h0000FFFF);
    wr(DLTC_CFG_ADDR, 32'h00000007);
    NRST = 1'b0;
    @(negedge MCLK);
    NRST = 1'b1;
    repeat (3) @(negedge MCLK);
    rd(DLTC_CFG_ADDR);
    chk("cfg after power-on reset", r, 32'h0);
    test_done();
  end
endmodule // testbench
